/* File: iad_defs.vh */
`ifndef IAD_DEFS_VH
`define IAD_DEFS_VH

// System clock period and the rate-select time step.
`define IAD_CLK_NS      50
`define IAD_T_STEP_NS   800
`define IAD_T_STEP_CYC  ((`IAD_T_STEP_NS + `IAD_CLK_NS - 1) / `IAD_CLK_NS)

// Timing counter width, word length and soft reset codes.
`define IAD_CNT_W       12
`define IAD_FULL_BITS   4'h8
`define IAD_GCALL_BYTE  8'h00
`define IAD_SRST_ARM    2'h2
`define IAD_SRST_FIRE   2'h1

// Receive FIFO shape.
`define IAD_FIFO_W      8
`define IAD_FIFO_DEPTH  32
`define IAD_FIFO_AW     5
`endif

/* File: iad_fifo.v */
`timescale 1ns/100ps
module iad_fifo #(
    parameter W     = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire         clock,
    input  wire         rst,
    input  wire         in_valid,
    input  wire [W-1:0] in_data,
    output wire         in_ready,
    output reg          out_valid,
    output reg  [W-1:0] out_data,
    input  wire         out_ready
);
    reg  [W-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0] wptr;
    reg  [AW-1:0] rptr;
    reg  [AW:0]   mcnt;
    wire          push;
    wire          pop;

    // The output stage is a register, so one word more than DEPTH fits.
    assign in_ready = (mcnt != DEPTH[AW:0]);
    assign push     = in_valid & in_ready;
    assign pop      = (mcnt != {(AW+1){1'b0}}) & (~out_valid | out_ready);

    // Storage writes need no reset.
    always @(posedge clock) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    // Pointers, fill count and the registered output word.
    always @(posedge clock) begin
        if (rst) begin
            wptr      <= {AW{1'b0}};
            rptr      <= {AW{1'b0}};
            mcnt      <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {W{1'b0}};
        end else begin
            if (push) begin
                wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wptr + 1'b1;
            end
            if (pop) begin
                rptr      <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                            : rptr + 1'b1;
                out_data  <= mem[rptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push & ~pop) begin
                mcnt <= mcnt + 1'b1;
            end else if (pop & ~push) begin
                mcnt <= mcnt - 1'b1;
            end
        end
    end
endmodule

/* File: iad_core.v */
`timescale 1ns/100ps
`include "iad_defs.vh"
module iad_core #(
    parameter CNT_W      = `IAD_CNT_W,
    parameter FIFO_DEPTH = `IAD_FIFO_DEPTH,
    parameter FIFO_AW    = `IAD_FIFO_AW
) (
    input  wire       clock,
    input  wire       rst,
    input  wire       interface_power_enable,
    input  wire       interface_mode_select,
    input  wire       free_format_select,
    input  wire [6:0] own_slave_address_field,
    input  wire       address_detect_disable,
    input  wire       ack_mode,
    input  wire [2:0] bit_count_field,
    input  wire [2:0] rate_select,
    input  wire       cr2_write,
    input  wire       wr_master_select,
    input  wire       wr_transmit_select,
    input  wire       wr_bus_occupied,
    input  wire       wr_service_pending,
    input  wire [1:0] wr_soft_reset_field,
    input  wire       dbr_write,
    input  wire [7:0] dbr_wdata,
    input  wire       dbr_read,
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        scl_out,
    output reg        scl_oe_n,
    output reg        sda_out,
    output reg        sda_oe_n,
    output reg        address_match_flag,
    output reg        general_call_flag,
    output reg        last_bit_flag,
    output reg        bus_occupied,
    output reg        master_select,
    output reg        transmit_select,
    output reg        service_pending,
    output reg        xfer_irq,
    output reg  [7:0] dbr_rdata,
    output wire       rx_valid,
    output wire [7:0] rx_data,
    input  wire       rx_ready
);
    localparam G_IDLE  = 2'h0;
    localparam G_START = 2'h1;
    localparam G_LOW   = 2'h2;
    localparam G_HIGH  = 2'h3;

    reg  [2:0]       scl_sync;
    reg  [2:0]       sda_sync;
    reg              scl_s;
    reg              sda_s;
    reg              scl_q;
    reg              sda_q;
    reg              srst_armed;
    reg              srst_pulse;
    reg  [3:0]       bit_cnt;
    reg  [7:0]       shreg;
    reg  [7:0]       tx_shift;
    reg              first_byte;
    reg              addressed;
    reg              dir_bit;
    reg  [1:0]       gen_state;
    reg  [CNT_W-1:0] gen_cnt;
    reg              gen_low;
    wire             lrst;
    wire             scl_rise;
    wire             scl_fall;
    wire             start_det;
    wire             stop_det;
    wire [3:0]       nbits;
    wire [3:0]       total;
    wire [3:0]       bit_inc;
    wire [7:0]       rx_full;
    wire             last_rise;
    wire             word_end;
    wire             addr_hit;
    wire             gc_hit;
    wire             ff_first;
    wire             engaged;
    wire             start_cmd;
    wire             ack_low;
    wire             data_low;
    wire             fifo_in_ready;
    wire             push;
    wire             stretch_cond;
    wire             stretch_now;
    wire [3:0]       rate_cnt;
    wire [31:0]      thigh_full;
    wire [CNT_W-1:0] thigh_cyc;
    wire [CNT_W-1:0] tlow_cyc;

    // The whole engine idles while the interface is unpowered or in
    // port mode, so a half-configured block never touches the bus.
    assign lrst = rst | srst_pulse | ~interface_power_enable
                | ~interface_mode_select;

    // Bus edges and conditions, seen only through the filtered levels.
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // Word length: a zero count field means a full eight-bit word.
    assign nbits   = (bit_count_field == 3'h0) ? `IAD_FULL_BITS
                                               : {1'b0, bit_count_field};
    assign total   = nbits + {3'h0, ack_mode};
    assign bit_inc = bit_cnt + 4'h1;
    assign rx_full = {shreg[6:0], sda_s};
    assign last_rise = scl_rise & (bit_inc == nbits);
    assign word_end  = scl_fall & (bit_cnt == total) & bus_occupied;
    assign engaged   = master_select | addressed;

    // Address compare uses the upper seven bits; bit zero is direction.
    assign addr_hit = ~address_detect_disable & ~free_format_select
                    & ~master_select & first_byte
                    & ((rx_full == `IAD_GCALL_BYTE)
                     | (rx_full[7:1] == own_slave_address_field));
    assign gc_hit   = ~address_detect_disable & ~free_format_select
                    & ~master_select & first_byte
                    & (rx_full == `IAD_GCALL_BYTE);
    assign ff_first = free_format_select & ~master_select & first_byte;

    // A start is only launched on a free bus with acknowledge clocks on.
    assign start_cmd = cr2_write & wr_master_select & wr_transmit_select
                     & wr_bus_occupied & wr_service_pending
                     & ~bus_occupied & ack_mode;

    // A slave acknowledges its own address even when it turns to send.
    assign ack_low  = ack_mode & engaged & (bit_cnt == nbits)
                    & (master_select ? ~transmit_select
                                     : (first_byte | ~transmit_select));
    assign data_low = engaged & (((bit_cnt < nbits) & transmit_select
                                  & ~tx_shift[7]) | ack_low);

    // Received data words go to the stream; the address byte does not.
    assign push = last_rise & ~transmit_select & (engaged | ff_first)
                & ~(first_byte & ~free_format_select);

    // SCL is held low while service_pending is clear or, when receiving, the FIFO is full.
    assign stretch_cond = engaged & bus_occupied
                        & (~service_pending
                         | (~transmit_select & ~fifo_in_ready));
    assign stretch_now  = stretch_cond & (~scl_s | ~scl_oe_n);

    // High time steps with the rate field; low time is twice as long.
    assign rate_cnt   = {1'b0, rate_select} + 4'h1;
    assign thigh_full = rate_cnt * `IAD_T_STEP_CYC;
    assign thigh_cyc  = thigh_full[CNT_W-1:0];
    assign tlow_cyc   = {thigh_cyc[CNT_W-2:0], 1'b0};

    // Three-stage pin synchronisers; a level is taken once the last two
    // stages agree, which also rejects single-sample glitches.
    always @(posedge clock) begin
        if (rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_s    <= 1'b1;
            sda_s    <= 1'b1;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            if (scl_sync[1] == scl_sync[2]) begin
                scl_s <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_s <= sda_sync[2];
            end
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Soft reset needs the arm code and then the fire code in turn.
    always @(posedge clock) begin
        if (rst) begin
            srst_armed <= 1'b0;
            srst_pulse <= 1'b0;
        end else begin
            srst_pulse <= 1'b0;
            if (cr2_write) begin
                srst_armed <= (wr_soft_reset_field == `IAD_SRST_ARM);
                srst_pulse <= srst_armed
                            & (wr_soft_reset_field == `IAD_SRST_FIRE);
            end
        end
    end

    // Bit engine, bus state and the software-visible control bits.
    always @(posedge clock) begin
        if (lrst) begin
            bit_cnt           <= 4'h0;
            shreg             <= 8'h00;
            tx_shift          <= 8'h00;
            first_byte        <= 1'b0;
            addressed         <= 1'b0;
            dir_bit           <= 1'b0;
            general_call_flag <= 1'b0;
            last_bit_flag     <= 1'b0;
            bus_occupied      <= 1'b0;
            master_select     <= 1'b0;
            transmit_select   <= 1'b0;
            service_pending   <= 1'b1;
            xfer_irq          <= 1'b0;
            dbr_rdata         <= 8'h00;
        end else begin
            xfer_irq <= 1'b0;
            if (cr2_write) begin
                master_select   <= wr_master_select;
                transmit_select <= wr_transmit_select;
            end
            if (start_cmd) begin
                dir_bit <= tx_shift[0];
            end
            if (dbr_write) begin
                tx_shift <= dbr_wdata;
            end
            if (start_det) begin
                bus_occupied      <= 1'b1;
                general_call_flag <= 1'b0;
                bit_cnt           <= 4'h0;
                first_byte        <= 1'b1;
                addressed         <= 1'b0;
            end else if (stop_det) begin
                bus_occupied      <= 1'b0;
                general_call_flag <= 1'b0;
                bit_cnt           <= 4'h0;
                first_byte        <= 1'b0;
                addressed         <= 1'b0;
                master_select     <= 1'b0;
                transmit_select   <= 1'b0;
            end else if (scl_rise) begin
                last_bit_flag <= sda_s;
                bit_cnt       <= bit_inc;
                if (bit_cnt < nbits) begin
                    shreg <= rx_full;
                    if (transmit_select & engaged) begin
                        tx_shift <= {tx_shift[6:0], 1'b0};
                    end
                end
                if (last_rise) begin
                    dbr_rdata <= rx_full;
                    if (addr_hit | ff_first) begin
                        addressed <= 1'b1;
                    end
                    if (addr_hit) begin
                        transmit_select <= rx_full[0];
                    end
                    if (gc_hit) begin
                        general_call_flag <= 1'b1;
                    end
                end
            end else if (word_end) begin
                // The ack sampled at the last rise is what is seen here.
                bit_cnt    <= 4'h0;
                first_byte <= 1'b0;
                if (engaged) begin
                    xfer_irq        <= 1'b1;
                    service_pending <= 1'b0;
                end
                if (master_select & first_byte & ~last_bit_flag) begin
                    transmit_select <= ~dir_bit;
                end
            end
            // Software can only set pending, and a set beats the clear.
            if (dbr_write | (cr2_write & wr_service_pending)) begin
                service_pending <= 1'b1;
            end
        end
    end

    // Match flag: set at the last data rise of the first word, and a set arriving
    // with a buffer access wins so the event is never dropped.
    always @(posedge clock) begin
        if (lrst) begin
            address_match_flag <= 1'b0;
        end else begin
            if (dbr_write | dbr_read) begin
                address_match_flag <= 1'b0;
            end
            if (last_rise & addr_hit) begin
                address_match_flag <= 1'b1;
            end
            if (last_rise & ff_first) begin
                address_match_flag <= 1'b1;
            end
        end
    end

    // Master clock generator. The high count restarts while another party holds
    // the line low and the low count while the core itself stretches, so slow slaves stretch the clock safely.
    always @(posedge clock) begin
        if (lrst) begin
            gen_state <= G_IDLE;
            gen_cnt   <= {CNT_W{1'b0}};
            gen_low   <= 1'b0;
        end else begin
            case (gen_state)
                G_IDLE: begin
                    gen_low <= 1'b0;
                    if (start_cmd) begin
                        gen_state <= G_START;
                        gen_cnt   <= thigh_cyc;
                    end
                end
                G_START: begin
                    if (gen_cnt == {CNT_W{1'b0}}) begin
                        gen_state <= G_LOW;
                        gen_low   <= 1'b1;
                        gen_cnt   <= tlow_cyc;
                    end else begin
                        gen_cnt <= gen_cnt - 1'b1;
                    end
                end
                G_LOW: begin
                    if (stretch_cond) begin
                        gen_cnt <= tlow_cyc;
                    end else if (gen_cnt == {CNT_W{1'b0}}) begin
                        gen_state <= G_HIGH;
                        gen_low   <= 1'b0;
                    end else begin
                        gen_cnt <= gen_cnt - 1'b1;
                    end
                end
                G_HIGH: begin
                    if (~scl_s) begin
                        gen_cnt <= thigh_cyc;
                    end else if (gen_cnt == {CNT_W{1'b0}}) begin
                        gen_state <= G_LOW;
                        gen_low   <= 1'b1;
                        gen_cnt   <= tlow_cyc;
                    end else begin
                        gen_cnt <= gen_cnt - 1'b1;
                    end
                end
                default: begin
                    gen_state <= G_IDLE;
                    gen_low   <= 1'b0;
                end
            endcase
            // Losing master mode (a stop) stops the generator once it is past G_START.
            if (~master_select & (gen_state != G_IDLE)
                & (gen_state != G_START)) begin
                gen_state <= G_IDLE;
                gen_low   <= 1'b0;
            end
        end
    end

    // Pin drivers. SDA only changes while SCL is low, except for the
    // start condition itself, so no false start or stop is produced.
    always @(posedge clock) begin
        if (lrst) begin
            scl_out  <= 1'b0;
            sda_out  <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            scl_out  <= 1'b0;
            sda_out  <= 1'b0;
            scl_oe_n <= ~(gen_low | stretch_now);
            if (gen_state == G_START) begin
                sda_oe_n <= 1'b0;
            end else if (~scl_s) begin
                sda_oe_n <= ~data_low;
            end
        end
    end

    iad_fifo #(
        .W     (`IAD_FIFO_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .rst       (lrst),
        .in_valid  (push),
        .in_data   (rx_full),
        .in_ready  (fifo_in_ready),
        .out_valid (rx_valid),
        .out_data  (rx_data),
        .out_ready (rx_ready)
    );
endmodule

/* File: iad_core_sva.sv */
`timescale 1ns/100ps
// Watches strobes, flags and pin enables of the core.
module iad_core_sva (
    input wire clock,
    input wire rst,
    input wire free_format_select,
    input wire address_detect_disable,
    input wire ack_mode,
    input wire cr2_write,
    input wire wr_master_select,
    input wire wr_transmit_select,
    input wire wr_bus_occupied,
    input wire wr_service_pending,
    input wire dbr_write,
    input wire dbr_read,
    input wire scl_oe_n,
    input wire sda_oe_n,
    input wire address_match_flag,
    input wire general_call_flag,
    input wire bus_occupied,
    input wire master_select,
    input wire service_pending,
    input wire xfer_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // A start only counts on a free bus with acknowledge clocks on.
    wire start_cmd = cr2_write && wr_master_select && wr_transmit_select
        && wr_bus_occupied && wr_service_pending && !bus_occupied && ack_mode;
    AST_DIS_MATCH: assert property (address_detect_disable
        && $past(address_detect_disable) && !free_format_select
        |-> !$rose(address_match_flag)) else $error("match while disabled");
    AST_DIS_GC: assert property (address_detect_disable
        && $past(address_detect_disable) |-> !$rose(general_call_flag))
        else $error("general call while disabled");
    AST_DBR_MATCH: assert property ((dbr_write || dbr_read)
        |=> !address_match_flag) else $error("match kept after access");
    AST_GC_MATCH: assert property ($rose(general_call_flag)
        |-> ##[0:1] address_match_flag) else $error("call without match");
    AST_GC_CLR: assert property ($changed(bus_occupied)
        |-> ##[0:2] !general_call_flag) else $error("call flag kept");
    AST_START: assert property (start_cmd
        |=> master_select ##1 !sda_oe_n) else $error("no start driven");
    AST_HIGH: assert property (start_cmd
        |=> scl_oe_n [*8]) else $error("clock fell too soon");
    AST_IRQ_PEND: assert property (xfer_irq
        |-> !service_pending) else $error("pending kept at interrupt");
    AST_HOLD: assert property (xfer_irq ##1 !service_pending
        |-> !scl_oe_n) else $error("clock not held low");
    AST_PEND_FALL: assert property ($fell(service_pending)
        |-> xfer_irq) else $error("pending cleared without interrupt");
    AST_DBR_PEND: assert property (dbr_write
        |=> service_pending) else $error("write left pending low");
    // Main scenarios.
    cover property (start_cmd);
    cover property ($rose(general_call_flag));
    cover property ($rose(address_match_flag) && free_format_select);
    cover property (xfer_irq);
endmodule
bind iad_core iad_core_sva iad_core_sva_i (.*);

/* File: iad_bus_master.sv */
`timescale 1ns/100ps
// Bus master on open-drain lines; a high output pulls the line low.
module iad_bus_master (
    input  wire clock,
    input  wire scl,
    input  wire sda,
    output reg  scl_low = 1'b0,
    output reg  sda_low = 1'b0
);
    reg ack = 1'b1;
    // A quarter of the 400 ns link period is two system clocks.
    task q;
        repeat (2) @(posedge clock);
    endtask
    // One clock pulse, low for six clocks and high for two, so a slave
    // answering through synchronisers settles before the rise; a slave
    // may still stretch the low phase at will.
    task bit_out(input logic v);
        begin
            sda_low <= !v;
            q;
            q;
            scl_low <= 1'b0;
            while (scl !== 1'b1) @(posedge clock);
            @(posedge clock);
            ack = sda;
            scl_low <= 1'b1;
            q;
        end
    endtask
    // Eight bits MSB first, then a released acknowledge bit.
    task send(input logic [7:0] d);
        integer k;
        begin
            for (k = 7; k >= 0; k--) bit_out(d[k]);
            bit_out(1'b1);
        end
    endtask
    // Data falls while the clock is high.
    task start;
        begin
            sda_low <= 1'b1;
            q;
            q;
            scl_low <= 1'b1;
            q;
        end
    endtask
    // Data rises while the clock is high.
    task stop;
        begin
            sda_low <= 1'b1;
            q;
            scl_low <= 1'b0;
            while (scl !== 1'b1) @(posedge clock);
            q;
            sda_low <= 1'b0;
            q;
            q;
        end
    endtask
endmodule

/* File: iad_core_tb.sv */
`timescale 1ns/100ps
// Master model on the bus, software by tasks, checks by one task.
module iad_core_tb;
    reg         clock = 1'b0, rst = 1'b1, rx_ready = 1'b0;
    reg         interface_power_enable = 1'b0, interface_mode_select = 1'b0;
    reg         free_format_select = 1'b0, address_detect_disable = 1'b0;
    reg         ack_mode = 1'b0, cr2_write = 1'b0, wr_master_select = 1'b0;
    reg         wr_transmit_select = 1'b0, wr_bus_occupied = 1'b0;
    reg         wr_service_pending = 1'b0, dbr_write = 1'b0, dbr_read = 1'b0;
    reg  [6:0]  own_slave_address_field = 7'h00;
    reg  [2:0]  bit_count_field = 3'h0, rate_select = 3'h0;
    reg  [1:0]  wr_soft_reset_field = 2'h0;
    reg  [7:0]  dbr_wdata = 8'h00;
    wire        scl_out, scl_oe_n, sda_out, sda_oe_n, address_match_flag;
    wire        general_call_flag, last_bit_flag, bus_occupied, master_select;
    wire        transmit_select, service_pending, xfer_irq, rx_valid;
    wire [7:0]  dbr_rdata, rx_data;
    wire        m_scl_low, m_sda_low;
    // Pulled-up wires: low while any party pulls.
    wire        scl_in = !(m_scl_low || !scl_oe_n);
    wire        sda_in = !(m_sda_low || !sda_oe_n);
    int         bad_count = 0, samples_checked = 0, irqs = 0, n, i;
    logic [7:0] b, q[$];
    always #25 clock = ~clock;
    // Counts interrupts so that refused bytes can be told apart.
    always @(posedge clock) if (xfer_irq === 1'b1) irqs <= irqs + 1;
    iad_core iad_core_i (.*);
    iad_bus_master iad_bus_master_i (.clock(clock), .scl(scl_in),
        .sda(sda_in), .scl_low(m_scl_low), .sda_low(m_sda_low));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        begin
            samples_checked++;
            if (seen !== exp) begin
                bad_count++;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One-cycle data buffer access; a write also releases a held clock.
    task sw(input logic wr);
        begin
            dbr_write <= wr;
            dbr_read <= !wr;
            @(posedge clock);
            dbr_write <= 1'b0;
            dbr_read <= 1'b0;
            @(posedge clock);
        end
    endtask
    // Control write; v at one makes it the start command.
    task cr2(input logic v);
        begin
            {wr_master_select, wr_transmit_select, wr_bus_occupied} <= {3{v}};
            wr_service_pending <= 1'b1;
            cr2_write <= 1'b1;
            @(posedge clock);
            cr2_write <= 1'b0;
        end
    endtask
    // Start and one byte, then time for the interrupt to land.
    task frame(input logic [7:0] d);
        begin
            n = irqs;
            iad_bus_master_i.start();
            iad_bus_master_i.send(d);
            repeat (10) @(posedge clock);
        end
    endtask
    task close;
        begin
            sw(1'b1);
            iad_bus_master_i.stop();
            repeat (6) @(posedge clock);
        end
    endtask
    task results;
        begin
            $display("checked=%0d bad=%0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Traffic needs some 4000 cycles; a hang is cut after 40000.
    initial begin
        #2000000;
        bad_count++;
        results;
    end
    initial begin
        void'($urandom(48));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        chk({address_match_flag, general_call_flag, bus_occupied,
            service_pending, scl_oe_n, sda_oe_n, scl_in, sda_in},
            8'h1f);
        chk({scl_out, sda_out}, 8'h00);
        interface_power_enable <= 1'b1;
        @(posedge clock);
        interface_mode_select <= 1'b1;
        ack_mode <= 1'b1;
        own_slave_address_field <= 7'($urandom_range(8, 119));
        repeat (6) @(posedge clock);
        cr2(1'b0);
        frame({own_slave_address_field, 1'b0});
        chk({address_match_flag, transmit_select, general_call_flag,
            bus_occupied}, 8'h09);
        chk({last_bit_flag, iad_bus_master_i.ack, scl_in}, 8'h00);
        chk({service_pending, 7'(irqs - n)}, 8'h01);
        chk(dbr_rdata, {own_slave_address_field, 1'b0});
        sw(1'b0);
        chk(address_match_flag, 1'b0);
        // Random data fills the FIFO and its output stage; the last word
        // fills them, so its acknowledge clock is held until a pop.
        for (i = 0; i < 33; i++) begin
            b = 8'($urandom);
            q.push_back(b);
            sw(1'b1);
            if (i < 32) begin
                iad_bus_master_i.send(b);
            end else begin
                fork
                    iad_bus_master_i.send(b);
                join_none
            end
            repeat (10) @(posedge clock);
        end
        repeat (80) @(posedge clock);
        chk(scl_in, 1'b0);
        // Random consumer; the handshake is looked at mid-cycle.
        for (i = 0; i < 2000 && q.size() > 0; i++) begin
            @(negedge clock);
            if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
                chk(rx_data, q.pop_front());
            end
            @(posedge clock);
            rx_ready <= 1'($urandom);
        end
        chk(8'(q.size()), 8'h00);
        rx_ready <= 1'b1;
        close;
        chk(bus_occupied, 1'b0);
        frame(8'h00);
        chk({general_call_flag, address_match_flag}, 8'h03);
        close;
        chk(general_call_flag, 1'b0);
        // Wrong address, then own address and call with detection off.
        for (i = 0; i < 3; i++) begin
            address_detect_disable <= (i > 0);
            b = {own_slave_address_field ^ 7'(i == 0), 1'b0};
            frame((i == 2) ? 8'h00 : b);
            chk({address_match_flag, general_call_flag, 6'(irqs - n)},
                8'h00);
            chk({last_bit_flag, iad_bus_master_i.ack}, 8'h03);
            close;
        end
        address_detect_disable <= 1'b0;
        // A set low bit must not be read as a direction.
        free_format_select <= 1'b1;
        rx_ready <= 1'b0;
        b = 8'($urandom) | 8'h01;
        frame(b);
        chk(address_match_flag, 1'b1);
        chk({rx_valid, transmit_select}, 8'h02);
        chk(rx_data, b);
        // Soft reset: arm code, a pause, then fire code; flags and FIFO go.
        wr_soft_reset_field <= 2'h2;
        cr2(1'b0);
        @(posedge clock);
        wr_soft_reset_field <= 2'h1;
        cr2(1'b0);
        wr_soft_reset_field <= 2'h0;
        repeat (2) @(posedge clock);
        chk({address_match_flag, bus_occupied, rx_valid}, 8'h00);
        rx_ready <= 1'b1;
        close;
        free_format_select <= 1'b0;
        rate_select <= 3'($urandom);
        dbr_wdata <= 8'($urandom);
        sw(1'b1);
        cr2(1'b1);
        for (n = 1; n < 300 && scl_oe_n !== 1'b0; n++) begin
            @(negedge clock);
            if (n == 2) chk({master_select, sda_oe_n}, 8'h02);
        end
        chk(8'(n - 16 * (rate_select + 1)), 8'h04);
        results;
    end
endmodule
